// *** bench/pos_far_end.sv ***
`timescale 1ns/1ns
module pos_far_end (
  input  wire logic       hclk,
  input  wire logic [3:0] req_on,
  input  wire logic [2:0] pair_low,
  output logic [3:0]      req_in_n,
  output logic            ch3_out_b,
  output logic            ch3_out_d,
  output logic            ch4_out_a,
  output logic            ch4_out_b,
  output logic            ch4_out_c,
  output logic            ch4_out_d
);
  logic ph = 1'b0;
  always @(posedge hclk) ph <= ~ph;
  // Pull-ups hold released request lines high
  assign req_in_n  = ~req_on;
  // Complementary phases overlap low only when commanded
  assign ch3_out_b = ph & ~pair_low[0];
  assign ch3_out_d = ~ph & ~pair_low[0];
  assign ch4_out_a = ph & ~pair_low[1];
  assign ch4_out_c = ~ph & ~pair_low[1];
  assign ch4_out_b = ph & ~pair_low[2];
  assign ch4_out_d = ~ph & ~pair_low[2];
endmodule

// *** bench/pos_unit_props.sv ***
`timescale 1ns/1ns
module pos_unit_props #(
  parameter int REQ_N = 4
)(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic [31:0]      hrdata,
  input wire logic             hresp,
  input wire logic [REQ_N-1:0] req_in_n,
  input wire logic             ch3_out_b,
  input wire logic             ch3_out_d,
  input wire logic             ch4_out_a,
  input wire logic             ch4_out_b,
  input wire logic             ch4_out_c,
  input wire logic             ch4_out_d,
  input wire logic             osc_stop,
  input wire logic             standby,
  input wire logic             pin_hiz,
  input wire logic             irq
);
  logic [4:0] since_cause;
  wire        pair_low = (!ch3_out_b && !ch3_out_d) ||
                         (!ch4_out_a && !ch4_out_c) ||
                         (!ch4_out_b && !ch4_out_d);
  wire        take     = hsel && htrans[1] && hready;
  // Saturates so a long quiet spell never wraps to a false cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      since_cause <= 5'h1f;
    else if (!(&req_in_n) || pair_low)
      since_cause <= 5'h00;
    else if (since_cause != 5'h1f)
      since_cause <= since_cause + 5'h01;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_stop_hiz: assert property (osc_stop || standby |-> pin_hiz)
    else $error("stop or standby without high impedance");
  a_hiz_cause: assert property
    ($rose(pin_hiz) && !osc_stop && !standby |-> since_cause < 5'h0c)
    else $error("high impedance without a recent cause");
  a_hiz_held: assert property
    ($fell(pin_hiz) && !$past(osc_stop) && !$past(standby)
     |-> $past(take && hwrite, 2))
    else $error("high impedance released without a write");
  a_irq_clear: assert property
    ($fell(irq) |-> $past(take && hwrite, 2))
    else $error("interrupt dropped without a write");
  a_irq_reset: assert property
    ($rose(hresetn) |-> !irq && (pin_hiz == (osc_stop || standby)))
    else $error("state not clear after reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!$past(take) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_rdata_upper: assert property
    ($past(take && !hwrite) |-> hrdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  cover property ($rose(pin_hiz) && !osc_stop);
  cover property ($fell(irq));
  cover property ($fell(pin_hiz) && !$past(standby));
endmodule

bind pos_unit pos_unit_props #(.REQ_N(REQ_N)) i_props (.hclk, .hresetn,
  .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
  .req_in_n, .ch3_out_b, .ch3_out_d, .ch4_out_a, .ch4_out_b, .ch4_out_c,
  .ch4_out_d, .osc_stop, .standby, .pin_hiz, .irq);

// *** bench/tb.sv ***
`timescale 1ns/1ns
module tb;
  import pos_pkg::*;
  typedef struct {logic [31:0] a, d, e;} pos_row_t;
  logic        hclk, hresetn, hsel, hwrite, osc_stop, standby;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pair_low;
  logic [3:0]  req_on;
  wire  [31:0] hrdata;
  wire  [3:0]  req_in_n;
  wire         hready, hresp, pin_hiz, irq, lite_hiz;
  wire         ch3_out_b, ch3_out_d, ch4_out_a, ch4_out_b, ch4_out_c;
  wire         ch4_out_d;
  int          fails, n_tests, n, dv;
  pos_row_t    rows [5] = '{
    '{POS_INLVL_ADDR, 32'h0000f1ff, 32'h000001ff},
    '{POS_OUTLVL_ADDR, 32'h0000ffff, 32'h00000300},
    '{POS_EVT_EN_ADDR, 32'h0000ffff, 32'h0000001f},
    '{POS_EVT_STAT_ADDR, 32'h0000ffff, 32'h00000000},
    '{32'hfffe0f20, 32'hffffffff, 32'h00000000}};

  always #20 hclk = ~hclk;
  pos_unit i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .req_in_n,
    .ch3_out_b, .ch3_out_d, .ch4_out_a, .ch4_out_b, .ch4_out_c, .ch4_out_d,
    .osc_stop, .standby, .pin_hiz, .irq);
  // Reduced variant sees the same traffic, never the comparison
  pos_unit #(.CMP_PRESENT(1'b0)) i_lite (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout(), .hrdata(),
    .hresp(), .req_in_n, .ch3_out_b, .ch3_out_d, .ch4_out_a, .ch4_out_b,
    .ch4_out_c, .ch4_out_d, .osc_stop, .standby, .pin_hiz(lite_hiz),
    .irq());
  pos_far_end i_far (.hclk, .req_on, .pair_low, .req_in_n, .ch3_out_b,
    .ch3_out_d, .ch4_out_a, .ch4_out_b, .ch4_out_c, .ch4_out_d);

  task summarize;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge hclk);
  endtask
  task wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
      k++;
      if (k > 50) begin
        fails++;
        summarize;
      end
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  task rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task wait_hiz(input int lim);
    n = 0;
    while (pin_hiz !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > lim) begin
        fails++;
        summarize;
      end
    end
  endtask

  initial begin
    {hclk, hresetn, hsel, hwrite, osc_stop, standby} = 6'h00;
    {haddr, hwdata, htrans, hsize, pair_low, req_on} = 76'h0;
    hsize = 3'h2;
    tick(5);
    hresetn <= 1'b1;
    rchk(POS_INLVL_ADDR, 32'h0);
    rchk(POS_OUTLVL_ADDR, 32'h0);
    chk({30'h0, pin_hiz, irq}, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    bus(1'b1, POS_OUTLVL_ADDR, 32'h0);
    bus(1'b1, POS_EVT_EN_ADDR, 32'h0);
    bus(1'b1, POS_INLVL_ADDR, 32'h100);
    for (int k = 0; k < 4; k++) begin
      req_on[k] <= 1'b1;
      tick(3);
      req_on[k] <= 1'b0;
      wait_hiz(20);
      chk({31'h0, irq}, 32'h1);
      // Clear without a prior read must not take
      bus(1'b1, POS_INLVL_ADDR, 32'h100);
      rchk(POS_INLVL_ADDR, 32'h100 | (32'h1000 << k));
      bus(1'b1, POS_INLVL_ADDR, 32'h100);
      tick(1);
      chk({30'h0, pin_hiz, irq}, 32'h0);
    end
    for (int m = 1; m < 4; m++) begin
      dv = (m == 3) ? 128 : 8 * m;
      bus(1'b1, POS_INLVL_ADDR, 32'(m) << 2);
      req_on[1] <= 1'b1;
      tick(10 * dv);
      req_on[1] <= 1'b0;
      tick(10);
      chk({31'h0, pin_hiz}, 32'h0);
      req_on[1] <= 1'b1;
      wait_hiz(17 * dv + 20);
      req_on[1] <= 1'b0;
      chk(32'(n >= 15 * dv && n <= 16 * dv + 12), 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, POS_INLVL_ADDR, 32'h0);
      bus(1'b1, POS_INLVL_ADDR, 32'(m) << 2);
    end
    bus(1'b1, POS_OUTLVL_ADDR, 32'h100);
    pair_low <= 3'h7;
    tick(4);
    pair_low <= 3'h0;
    tick(6);
    chk({31'h0, pin_hiz}, 32'h0);
    bus(1'b1, POS_OUTLVL_ADDR, 32'h300);
    for (int p = 0; p < 3; p++) begin
      pair_low[p] <= 1'b1;
      tick(1);
      pair_low[p] <= 1'b0;
      tick(6);
      chk({31'h0, pin_hiz}, 32'h0);
      pair_low[p] <= 1'b1;
      tick(2);
      pair_low[p] <= 1'b0;
      wait_hiz(10);
      chk({30'h0, irq, lite_hiz}, 32'h2);
      rchk(POS_OUTLVL_ADDR, 32'h8300);
      bus(1'b1, POS_OUTLVL_ADDR, 32'h300);
      tick(1);
      chk({31'h0, pin_hiz}, 32'h0);
    end
    rchk(POS_EVT_STAT_ADDR, 32'h1f);
    bus(1'b1, POS_EVT_EN_ADDR, 32'h10);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, POS_EVT_CLR_ADDR, 32'h10);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    rchk(POS_EVT_STAT_ADDR, 32'h0f);
    osc_stop <= 1'b1;
    tick(1);
    chk({31'h0, pin_hiz}, 32'h1);
    osc_stop <= 1'b0;
    standby  <= 1'b1;
    tick(1);
    chk({31'h0, pin_hiz}, 32'h1);
    standby <= 1'b0;
    bus(1'b1, POS_INLVL_ADDR, 32'h1ff);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    rchk(POS_INLVL_ADDR, 32'h0);
    summarize;
  end
endmodule

// *** design/pos_req_detect.sv ***
`timescale 1ns/1ns
module pos_req_detect
  import pos_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      req_n,
  input  wire pos_mode_t mode,
  input  wire logic      tick8,
  input  wire logic      tick16,
  input  wire logic      tick128,
  output logic           detect
);

  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       level;
  logic       level_d;
  logic [4:0] low_cnt;
  logic       next_detect;
  logic       tick_sel;
  logic       edge_hit;
  logic       sample_hit;

  assign tick_sel = (mode == POS_MODE_DIV8)   ? tick8 :
                    (mode == POS_MODE_DIV16)  ? tick16 :
                    (mode == POS_MODE_DIV128) ? tick128 : 1'b0;
  assign edge_hit = (mode == POS_MODE_EDGE) && level_d && !level; // RQ1
  // Fires once, on the sixteenth consecutive low sample
  assign sample_hit = tick_sel && !level &&
                      (low_cnt == POS_SAMPLE_COUNT - 5'h01); // RQ1
  assign next_detect = edge_hit || sample_hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
    end else begin
      sync1 <= req_n;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Level only moves once two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level   <= 1'b1;
      level_d <= 1'b1;
    end else begin
      level_d <= level;
      if (sync2 == sync3) begin
        level <= sync3;
      end
    end
  end

  // Counter saturates so a held low reports only once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= 5'h00;
    end else if (level || mode == POS_MODE_EDGE) begin
      low_cnt <= 5'h00;
    end else if (tick_sel && low_cnt != POS_SAMPLE_COUNT) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      detect <= 1'b0;
    end else begin
      detect <= next_detect;
    end
  end

endmodule

// *** design/pos_unit.sv ***
`timescale 1ns/1ns
//
// Overview of operation
// RQ1 - Each request input: falling edge or sixteen lows
// RQ2 - Any detected request tri-states all high-current pins
// RQ3 - Paired outputs low over one cycle tri-state
// RQ4 - Comparison absent in the reduced variant
// RQ5 - Interrupts from input detection and output comparison
// RQ6 - Oscillator stop or standby forces high impedance
// RQ7 - Software clears request flags writing zero only
// RQ8 - Software clears comparison flag writing zero only
// RQ9 - Output register: comparison enable, interrupt enable
// RQ10 - Interrupt while port enable and any flag
// RQ11 - Flag clears by zero write after reading one
// RQ12 - Mode 00 edge, 01/10/11 divide 8/16/128
// RQ13 - Input register cleared by power-on reset only
// RQ14 - High impedance holds until all flags cleared
module pos_unit
  import pos_pkg::*;
#(
  parameter bit CMP_PRESENT = 1'b1,
  parameter int REQ_N       = 4
)(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic [REQ_N-1:0] req_in_n,
  input  wire logic             ch3_out_b,
  input  wire logic             ch3_out_d,
  input  wire logic             ch4_out_a,
  input  wire logic             ch4_out_b,
  input  wire logic             ch4_out_c,
  input  wire logic             ch4_out_d,
  input  wire logic             osc_stop,
  input  wire logic             standby,
  output logic                  pin_hiz,
  output logic                  irq
);

  // Bus data phase
  logic                  addr_take;
  logic                  dp_valid;
  logic                  dp_write;
  logic                  hit_inlvl;
  logic                  hit_outlvl;
  logic                  hit_stat;
  logic                  hit_clr;
  logic                  hit_en;
  logic                  dp_inlvl;
  logic                  dp_outlvl;
  logic                  dp_stat;
  logic                  dp_clr;
  logic                  dp_en;
  logic                  wr_inlvl;
  logic                  wr_outlvl;
  logic                  wr_clr;
  logic                  wr_en;
  logic                  rd_inlvl;
  logic                  rd_outlvl;
  logic                  rd_stat;
  logic                  rd_en;
  logic [15:0]           inlvl_view;
  logic [15:0]           outlvl_view;
  logic [31:0]           rd_word_inlvl;
  logic [31:0]           rd_word_outlvl;
  logic [31:0]           rd_word_stat;
  logic [31:0]           rd_word_en;
  logic [31:0]           rd_mux;

  // Control registers
  logic [REQ_N-1:0]      req_flag;
  logic [REQ_N-1:0]      next_req_flag;
  logic [REQ_N-1:0]      req_seen;
  logic [REQ_N-1:0]      req_clr;
  logic                  port_interrupt_enable;
  logic [2*REQ_N-1:0]    mode_bits;
  logic                  osf;
  logic                  next_osf;
  logic                  osf_seen;
  logic                  osf_clr;
  logic                  oce;
  logic                  oie;

  // Event block
  logic [POS_EVT_W-1:0]  evt_status;
  logic [POS_EVT_W-1:0]  evt_en;
  logic [POS_EVT_W-1:0]  evt_pulse;
  logic [POS_EVT_W-1:0]  evt_wclr;

  // Detection
  logic [6:0]            presc;
  logic                  tick8;
  logic                  tick16;
  logic                  tick128;
  logic [REQ_N-1:0]      req_det;
  logic [2:0]            pair_low;
  logic [2:0]            pair_hit;
  logic                  cmp_hit;
  logic                  cmp_event;

  // ---------------- Bus slave ----------------
  // Zero-wait slave; every access completes with OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_take = hsel && hready && htrans[1];

  // Full address compare, so no register has an alias
  assign hit_inlvl  = haddr == POS_INLVL_ADDR;
  assign hit_outlvl = haddr == POS_OUTLVL_ADDR;
  assign hit_stat   = haddr == POS_EVT_STAT_ADDR;
  assign hit_clr    = haddr == POS_EVT_CLR_ADDR;
  assign hit_en     = haddr == POS_EVT_EN_ADDR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
    end else begin
      dp_valid <= addr_take;
      dp_write <= addr_take && hwrite;
    end
  end

  // Register selects held through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_inlvl  <= 1'b0;
      dp_outlvl <= 1'b0;
      dp_stat   <= 1'b0;
      dp_clr    <= 1'b0;
      dp_en     <= 1'b0;
    end else begin
      dp_inlvl  <= addr_take && hit_inlvl;
      dp_outlvl <= addr_take && hit_outlvl;
      dp_stat   <= addr_take && hit_stat;
      dp_clr    <= addr_take && hit_clr;
      dp_en     <= addr_take && hit_en;
    end
  end

  assign wr_inlvl  = dp_write && dp_inlvl;
  assign wr_outlvl = dp_write && dp_outlvl;
  assign wr_clr    = dp_write && dp_clr;
  assign wr_en     = dp_write && dp_en;
  assign rd_inlvl  = dp_valid && !dp_write && dp_inlvl;
  assign rd_outlvl = dp_valid && !dp_write && dp_outlvl;
  assign rd_stat   = dp_valid && !dp_write && dp_stat;
  assign rd_en     = dp_valid && !dp_write && dp_en;

  // Reserved bits read as zero
  assign inlvl_view  = {req_flag, 3'b000, port_interrupt_enable, mode_bits};
  assign outlvl_view = {osf, 5'b00000, oce, oie, 8'h00};

  // Each word is zero unless its own register is read
  assign rd_word_inlvl  = rd_inlvl ? {16'h0000, inlvl_view} :
                                     32'h0000_0000;
  assign rd_word_outlvl = rd_outlvl ? {16'h0000, outlvl_view} :
                                      32'h0000_0000;
  assign rd_word_stat   = rd_stat ? {27'h0, evt_status} :
                                    32'h0000_0000;
  assign rd_word_en     = rd_en ? {27'h0, evt_en} : 32'h0000_0000;

  // Unmapped addresses and the clear register read as zero
  assign rd_mux = rd_word_inlvl | rd_word_outlvl |
                  rd_word_stat | rd_word_en;

  // Read data is the register view during the data phase
  assign hrdata = rd_mux;

  // ---------------- Prescaler taps ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= 7'h00;
    end else begin
      presc <= presc + 7'h01;
    end
  end

  // Taps fire once per 8, 16 and 128 clocks
  assign tick8   = (presc & POS_DIV8_MASK)   == POS_DIV8_MASK; // RQ12
  assign tick16  = (presc & POS_DIV16_MASK)  == POS_DIV16_MASK; // RQ12
  assign tick128 = (presc & POS_DIV128_MASK) == POS_DIV128_MASK; // RQ12

  // ---------------- Request inputs ----------------
  genvar gi;
  generate
    for (gi = 0; gi < REQ_N; gi++) begin : g_req
      pos_req_detect u_det (
        .hclk    (hclk),
        .hresetn (hresetn),
        .req_n   (req_in_n[gi]),
        .mode    (pos_mode_t'(mode_bits[2*gi +: 2])),
        .tick8   (tick8),
        .tick16  (tick16),
        .tick128 (tick128),
        .detect  (req_det[gi])
      ); // RQ1

      // Zero clears only a flag already read as one
      assign req_clr[gi] = wr_inlvl && req_seen[gi] &&
        !hwdata[POS_REQ_FLAG_LSB + gi]; // RQ7
    end
  endgenerate

  // A new detection outlives a clear in the same cycle
  assign next_req_flag = (req_flag & ~req_clr) | req_det; // RQ11

  // hresetn is the power-on reset; no other reset reaches this
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_flag <= POS_INLVL_RESET[POS_REQ_FLAG_LSB +: REQ_N]; // RQ13
    end else begin
      req_flag <= next_req_flag; // RQ11
    end
  end

  // Control bits keep their value through standby and sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_interrupt_enable       <= POS_INLVL_RESET[POS_PIE_BIT];
      mode_bits <= POS_INLVL_RESET[POS_MODE_LSB +: 2*REQ_N];
    end else if (wr_inlvl) begin
      port_interrupt_enable       <= hwdata[POS_PIE_BIT]; // RQ9
      mode_bits <= hwdata[POS_MODE_LSB +: 2*REQ_N]; // RQ12
    end
  end

  // Remember which flags software has seen set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_seen <= '0;
    end else begin
      req_seen <= (req_seen | (rd_inlvl ? req_flag : '0)) &
                  next_req_flag; // RQ11
    end
  end

  // ---------------- Output comparison ----------------
  assign pair_low[0] = !ch3_out_b && !ch3_out_d; // RQ3
  assign pair_low[1] = !ch4_out_a && !ch4_out_c; // RQ3
  assign pair_low[2] = !ch4_out_b && !ch4_out_d; // RQ3

  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      logic [1:0] run;
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          run <= 2'h0;
        end else if (!pair_low[gi]) begin
          run <= 2'h0;
        end else if (run != POS_LOW_MIN_CYCLES) begin
          run <= run + 2'h1;
        end
      end
      // Hit on the second consecutive low cycle
      assign pair_hit[gi] = pair_low[gi] &&
        (run == POS_LOW_MIN_CYCLES - 2'h1); // RQ3
    end
  endgenerate

  // The reduced variant still builds the pair counters but masks every hit
  assign cmp_hit = CMP_PRESENT && oce && (|pair_hit); // RQ4

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_event <= 1'b0;
    end else begin
      cmp_event <= cmp_hit;
    end
  end

  assign osf_clr  = wr_outlvl && osf_seen && !hwdata[POS_OSF_BIT]; // RQ8
  // A new hit outlives a clear in the same cycle
  assign next_osf = (osf && !osf_clr) || cmp_event;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osf <= POS_OUTLVL_RESET[POS_OSF_BIT];
    end else begin
      osf <= next_osf; // RQ8
    end
  end

  // Cleared with the flag, so a stale read never arms a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osf_seen <= 1'b0;
    end else begin
      osf_seen <= (osf_seen || (rd_outlvl && osf)) && next_osf;
    end
  end

  // Reduced variant keeps both enables at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oce <= POS_OUTLVL_RESET[POS_OCE_BIT];
      oie <= POS_OUTLVL_RESET[POS_OIE_BIT];
    end else if (wr_outlvl) begin
      oce <= CMP_PRESENT && hwdata[POS_OCE_BIT]; // RQ9
      oie <= CMP_PRESENT && hwdata[POS_OIE_BIT]; // RQ9
    end
  end

  // ---------------- Event status ----------------
  assign evt_pulse = {cmp_event, req_det};
  assign evt_wclr  = wr_clr ? hwdata[POS_EVT_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_status <= POS_EVT_RESET;
    end else begin
      // Set wins over a clear in the same cycle
      evt_status <= (evt_status & ~evt_wclr) | evt_pulse; // RQ5
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_en <= POS_EVT_RESET;
    end else if (wr_en) begin
      evt_en <= hwdata[POS_EVT_W-1:0];
    end
  end

  // ---------------- Outputs ----------------
  // Level interrupt; the event block adds a per-source view
  assign irq = (port_interrupt_enable && (|req_flag)) || // RQ10
               (oie && osf) || // RQ5
               (|(evt_status & evt_en));

  // Held off only once every flag has been cleared.
  // Oscillator stop and standby act regardless of pin function.
  assign pin_hiz = (|req_flag) || // RQ2
                   osf || // RQ14
                   osc_stop || standby; // RQ6

endmodule

// *** include/pos_pkg.sv ***
package pos_pkg;

  // Offsets are not all word aligned, so they are kept as
  // indices and each register sits at four times its index.
  localparam logic [31:0] POS_INLVL_INDEX    = 32'hffff83c0;
  localparam logic [31:0] POS_OUTLVL_INDEX   = 32'hffff83c2;
  localparam logic [31:0] POS_INLVL_ADDR     =
    {POS_INLVL_INDEX[29:0], 2'b00};
  localparam logic [31:0] POS_OUTLVL_ADDR    =
    {POS_OUTLVL_INDEX[29:0], 2'b00};
  localparam logic [31:0] POS_EVT_STAT_ADDR  = 32'hfffe0f10;
  localparam logic [31:0] POS_EVT_CLR_ADDR   = 32'hfffe0f14;
  localparam logic [31:0] POS_EVT_EN_ADDR    = 32'hfffe0f18;

  // Input-level register fields
  localparam int          POS_REQ_FLAG_LSB   = 12;
  localparam int          POS_PIE_BIT        = 8;
  localparam int          POS_MODE_LSB       = 0;
  // Output-level register fields
  localparam int          POS_OSF_BIT        = 15;
  localparam int          POS_OCE_BIT        = 9;
  localparam int          POS_OIE_BIT        = 8;

  localparam logic [15:0] POS_INLVL_RESET    = 16'h0000;
  localparam logic [15:0] POS_OUTLVL_RESET   = 16'h0000;
  localparam logic [4:0]  POS_EVT_RESET      = 5'h00;

  // Event bits: 3..0 request inputs, 4 output comparison
  localparam int          POS_EVT_W          = 5;
  localparam int          POS_EVT_CMP        = 4;

  // Sampling: sixteen low samples on a prescaler tap
  localparam logic [4:0]  POS_SAMPLE_COUNT   = 5'h10;
  localparam logic [6:0]  POS_DIV8_MASK      = 7'h07;
  localparam logic [6:0]  POS_DIV16_MASK     = 7'h0f;
  localparam logic [6:0]  POS_DIV128_MASK    = 7'h7f;
  // Simultaneous low must last longer than one cycle
  localparam logic [1:0]  POS_LOW_MIN_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    POS_MODE_EDGE   = 2'b00,
    POS_MODE_DIV8   = 2'b01,
    POS_MODE_DIV16  = 2'b10,
    POS_MODE_DIV128 = 2'b11
  } pos_mode_t;

endpackage
